// *** oxs_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the overexcitation stage
`ifndef OXS_REGS_SVH
`define OXS_REGS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OXS_CTRL_OFF     8'h00
`define OXS_FORCE_OFF    8'h04
`define OXS_GSEL_OFF     8'h08
`define OXS_GIDX_OFF     8'h0c
`define OXS_PICKUP_OFF   8'h10
`define OXS_DELAY_OFF    8'h14
`define OXS_ALARM_OFF    8'h18
`define OXS_DTYPE_OFF    8'h1c
`define OXS_COND_OFF     8'h20
`define OXS_STS_OFF      8'h24
`define OXS_MASK_OFF     8'h28
`define OXS_CNT_ST_OFF   8'h2c
`define OXS_CNT_TR_OFF   8'h30
`define OXS_CNT_BL_OFF   8'h34
`define OXS_CNT_CLR_OFF  8'h38
`define OXS_NOM_OFF      8'h3c
`define OXS_EVT_TS_OFF   8'h40
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OXS_CTRL_FORCE_EN_BIT 0
`define OXS_CTRL_BLOCK_BIT    1
`define OXS_PICKUP_RST   16'h01f4
`define OXS_DELAY_RST    20'h00028
`define OXS_NOM_RST      32'h00010000
`define OXS_HYST_NUM     7'h61
`define OXS_HYST_DEN     7'h64
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OXS_CLK_HZ       10000000
`define OXS_TICK_MS      1
`define OXS_TICK_CYC     ((`OXS_CLK_HZ / 1000) * `OXS_TICK_MS)
`define OXS_BASE_MS      5
`endif

// *** oxs_pkg.sv ***
// Types shared by the overexcitation stage
package oxs_pkg;
   typedef enum logic [1:0] {OXS_F_NORMAL, OXS_F_START, OXS_F_TRIP, OXS_F_BLOCKED} oxs_force_t;
   typedef enum logic [2:0] {OXS_C_NORMAL, OXS_C_START, OXS_C_ALARM, OXS_C_TRIP, OXS_C_BLOCKED} oxs_cond_t;
   typedef enum logic [1:0] {OXS_D_FIXED, OXS_D_INVERSE, OXS_D_BOTH} oxs_dtype_t;
endpackage

// *** oxs_stage.sv ***
// Volts-per-hertz overexcitation stage with Wishbone registers and event output
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`include "oxs_regs.svh"
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Ratio of largest line voltage to frequency
// - Take new measurements each 5 ms base
// - Fixed order: magnitude, compare, block, delay, output
// - Block and group change without restart
// - Eight parameter sets, one select source
// - Start, trip and blocked outputs
// - Event on each edge of each output
// - Zero delay: start and trip share stamp
// - Event stamps at one millisecond resolution
// - Clearable counters of start, trip, blocked
// - Forced status drives outputs when enabled
// - Forced status kept outside setting groups
// - Release below 97 percent of pick-up
// - Start only while not blocked
// - Delay type fixed, inverse or both; all codes timed as fixed delay
// - Readable condition normal to blocked, 0-4
module oxs_stage
#(
   parameter int VW = 16,
   parameter int FW = 16,
   parameter int NG = 8
)
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_b,
   // Wishbone slave
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   // Measurements, valid once per time base
   input  wire logic          meas_valid,
   input  wire logic [VW-1:0] line_voltage_rms_12,
   input  wire logic [VW-1:0] line_voltage_rms_23,
   input  wire logic [VW-1:0] line_voltage_rms_31,
   input  wire logic [FW-1:0] freq_meas,
   // External block and group select
   input  wire logic          block_in,
   input  wire logic [2:0]    group_sel_in,
   // Stage outputs
   output logic               start_out,
   output logic               trip_out,
   output logic               blocked_out,
   // Event buffer port
   output logic               evt_valid,
   output logic [2:0]         evt_code,
   output logic               evt_on,
   output logic [31:0]        evt_stamp,
   // Interrupt
   output logic               irq
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [1:0]  ctrl_reg;
   logic [1:0]  force_reg;
   logic        gsel_sw_reg;
   logic [2:0]  gsel_val_reg;
   logic [2:0]  gidx_reg;
   logic [15:0] pickup_reg [NG];
   logic [19:0] delay_reg  [NG];
   logic [19:0] alarm_reg  [NG];
   logic [1:0]  dtype_reg  [NG];
   logic [31:0] nom_reg;
   logic [2:0]  sts_reg;
   logic [2:0]  mask_reg;
   logic [31:0] cnt_reg [3];
   logic        wr;
   logic        rd;
   logic [2:0]  grp;
   logic [2:0]  cnt_clr;

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hf;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign cnt_clr = (wr && wb_adr_i == `OXS_CNT_CLR_OFF) ? wb_dat_i[2:0] : 3'h0;
   // Active group: one common source, software or external pin
   assign grp = gsel_sw_reg ? gsel_val_reg : group_sel_in;

   // Ack one cycle after the strobe, dropped the next cycle
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   // Global settings, kept apart from the groups
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_reg     <= 2'h0;
         force_reg    <= 2'h0;
         gsel_sw_reg  <= 1'b0;
         gsel_val_reg <= 3'h0;
         gidx_reg     <= 3'h0;
         nom_reg      <= `OXS_NOM_RST;
         mask_reg     <= 3'h0;
      end
      else if (wr)
      begin
         case (wb_adr_i)
            `OXS_CTRL_OFF:  ctrl_reg <= wb_dat_i[1:0];
            `OXS_FORCE_OFF: force_reg <= wb_dat_i[1:0];
            `OXS_GSEL_OFF:
            begin
               gsel_val_reg <= wb_dat_i[2:0];
               gsel_sw_reg  <= wb_dat_i[3];
            end
            `OXS_GIDX_OFF:  gidx_reg <= wb_dat_i[2:0];
            `OXS_NOM_OFF:   nom_reg <= wb_dat_i;
            `OXS_MASK_OFF:  mask_reg <= wb_dat_i[2:0];
            default: ;
         endcase
      end
   end

   // Per-group settings, written through the group index; running logic never stops
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < NG; i++)
         begin
            pickup_reg[i] <= `OXS_PICKUP_RST;
            delay_reg[i]  <= `OXS_DELAY_RST;
            alarm_reg[i]  <= `OXS_DELAY_RST;
            dtype_reg[i]  <= 2'h0;
         end
      end
      else if (wr)
      begin
         case (wb_adr_i)
            `OXS_PICKUP_OFF: pickup_reg[gidx_reg] <= wb_dat_i[15:0];
            `OXS_DELAY_OFF:  delay_reg[gidx_reg] <= wb_dat_i[19:0];
            `OXS_ALARM_OFF:  alarm_reg[gidx_reg] <= wb_dat_i[19:0];
            `OXS_DTYPE_OFF:  dtype_reg[gidx_reg] <= (wb_dat_i[1:0] == 2'h3) ? 2'h0 : wb_dat_i[1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Millisecond time stamp
   // ----------------------------------------------------------------
   localparam int TICKW = $clog2(`OXS_TICK_CYC);
   logic [TICKW-1:0] div_reg;
   logic             ms_tick;
   logic [31:0]      ms_reg;
   assign ms_tick = div_reg == TICKW'(`OXS_TICK_CYC - 1);

   // Stamp counts whole milliseconds since reset
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_reg <= '0;
         ms_reg  <= 32'h0;
      end
      else if (ms_tick)
      begin
         div_reg <= '0;
         ms_reg  <= ms_reg + 32'h1;
      end
      else
         div_reg <= div_reg + TICKW'(1);
   end

   // ----------------------------------------------------------------
   // Evaluation pipeline
   // ----------------------------------------------------------------
   function automatic logic [VW-1:0] max3(input logic [VW-1:0] a, input logic [VW-1:0] b,
                                          input logic [VW-1:0] c);
      logic [VW-1:0] m;
      m = (a > b) ? a : b;
      return (m > c) ? m : c;
   endfunction

   logic [VW-1:0] vmax_reg;
   logic [FW-1:0] f_reg;
   logic          s1_reg;
   logic [47:0]   lhs;
   logic [47:0]   thr;
   logic [47:0]   thr_rel;
   logic          pickup_reg_q;
   logic          blk;

   // Stage 1: latch largest line voltage on each new time base
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         vmax_reg <= '0;
         f_reg    <= '0;
         s1_reg   <= 1'b0;
      end
      else
      begin
         s1_reg <= meas_valid;
         if (meas_valid)
         begin
            vmax_reg <= max3(line_voltage_rms_12, line_voltage_rms_23, line_voltage_rms_31);
            f_reg    <= freq_meas;
         end
      end
   end

   // Compare V*2^16 against nom*f*(1+p/10000); the threshold is computed with a division by 10000
   assign lhs = {vmax_reg, 32'h0} >> 16;
   assign thr = 48'((64'(nom_reg) * 64'(f_reg) * (64'h2710 + 64'(pickup_reg[grp]))) / 64'h2710);
   assign thr_rel = 48'((64'(thr) * 64'(`OXS_HYST_NUM)) / 64'(`OXS_HYST_DEN));

   // Stage 2: threshold with hysteresis; zero frequency never picks up
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pickup_reg_q <= 1'b0;
      end
      else
      begin
         if (s1_reg)
         begin
            if (f_reg == '0)
               pickup_reg_q <= 1'b0;
            else if (lhs > thr)
               pickup_reg_q <= 1'b1;
            else if (lhs < thr_rel)
               pickup_reg_q <= 1'b0;
         end
      end
   end

   // Block check from pin or control bit, evaluated live
   assign blk = block_in || ctrl_reg[`OXS_CTRL_BLOCK_BIT];

   // Stage 3: delay timers count in 5 ms steps of the time base
   // The base that first picks up adds no time, so a set delay is never cut short by one step
   logic [19:0] op_ms_reg;
   logic        start_n;
   logic        trip_n;
   logic        alarm_n;
   logic [19:0] op_lim;
   assign op_lim = delay_reg[grp];
   assign start_n = pickup_reg_q && !blk;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         op_ms_reg <= 20'h0;
      else if (!start_n)
         op_ms_reg <= 20'h0;
      else if (s1_reg && op_ms_reg < 20'hfffff - 20'd5)
         op_ms_reg <= op_ms_reg + 20'(`OXS_BASE_MS);
   end

   // Inverse variants treated as fixed-delay here; curve math lives upstream
   assign trip_n  = start_n && (op_ms_reg >= op_lim);
   assign alarm_n = start_n && (op_ms_reg >= alarm_reg[grp]);

   // Stage 4: outputs, forced status overrides when enabled
   logic [2:0] out_n;
   always_comb
   begin
      out_n = {blk, trip_n, start_n};
      if (ctrl_reg[`OXS_CTRL_FORCE_EN_BIT])
      begin
         case (oxs_pkg::oxs_force_t'(force_reg))
            oxs_pkg::OXS_F_START:   out_n = 3'b001;
            oxs_pkg::OXS_F_TRIP:    out_n = 3'b011;
            oxs_pkg::OXS_F_BLOCKED: out_n = 3'b100;
            default:                out_n = 3'b000;
         endcase
      end
   end

   oxs_pkg::oxs_cond_t cond_reg;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         start_out   <= 1'b0;
         trip_out    <= 1'b0;
         blocked_out <= 1'b0;
         cond_reg    <= oxs_pkg::OXS_C_NORMAL;
      end
      else
      begin
         start_out   <= out_n[0];
         trip_out    <= out_n[1];
         blocked_out <= out_n[2];
         if (out_n[2])
            cond_reg <= oxs_pkg::OXS_C_BLOCKED;
         else if (out_n[1])
            cond_reg <= oxs_pkg::OXS_C_TRIP;
         else if (alarm_n)
            cond_reg <= oxs_pkg::OXS_C_ALARM;
         else if (out_n[0])
            cond_reg <= oxs_pkg::OXS_C_START;
         else
            cond_reg <= oxs_pkg::OXS_C_NORMAL;
      end
   end

   // ----------------------------------------------------------------
   // Events, counters and interrupt
   // ----------------------------------------------------------------
   logic [2:0] prev_reg;
   logic [2:0] chg;
   logic [2:0] pend_reg;
   logic [2:0] pend_on_reg;
   logic [1:0] pick;
   logic       pick_v;
   assign chg = {blocked_out, trip_out, start_out} ^ prev_reg;

   // Lowest pending edge goes out first; one event per cycle
   always_comb
   begin
      pick   = 2'd0;
      pick_v = 1'b0;
      for (int i = 2; i >= 0; i--)
      begin
         if (pend_reg[i])
         begin
            pick   = 2'(i);
            pick_v = 1'b1;
         end
      end
   end

   // Edges queue per output; stamp is taken at the edge so start and trip match
   logic [31:0] stamp_reg [3];
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prev_reg    <= 3'h0;
         pend_reg    <= 3'h0;
         pend_on_reg <= 3'h0;
         evt_valid   <= 1'b0;
         evt_code    <= 3'h0;
         evt_on      <= 1'b0;
         evt_stamp   <= 32'h0;
         for (int i = 0; i < 3; i++)
            stamp_reg[i] <= 32'h0;
      end
      else
      begin
         prev_reg  <= {blocked_out, trip_out, start_out};
         evt_valid <= pick_v;
         if (pick_v)
         begin
            evt_code  <= {1'b0, pick};
            evt_on    <= pend_on_reg[pick];
            evt_stamp <= stamp_reg[pick];
         end
         for (int i = 0; i < 3; i++)
         begin
            if (chg[i])
            begin
               pend_reg[i]    <= 1'b1;
               pend_on_reg[i] <= ~prev_reg[i];
               stamp_reg[i]   <= ms_reg;
            end
            else if (pick_v && pick == 2'(i))
               pend_reg[i] <= 1'b0;
         end
      end
   end

   // Counters count ON edges; an edge in the clear cycle still counts
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         for (int i = 0; i < 3; i++)
            cnt_reg[i] <= 32'h0;
      else
         for (int i = 0; i < 3; i++)
         begin
            if (chg[i] && !prev_reg[i])
               cnt_reg[i] <= cnt_clr[i] ? 32'h1 : cnt_reg[i] + 32'h1;
            else if (cnt_clr[i])
               cnt_reg[i] <= 32'h0;
         end
   end

   // Sticky status, write one to clear, set wins
   logic [2:0] sts_clr;
   assign sts_clr = (wr && wb_adr_i == `OXS_STS_OFF) ? wb_dat_i[2:0] : 3'h0;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sts_reg <= 3'h0;
         irq     <= 1'b0;
      end
      else
      begin
         sts_reg <= (sts_reg & ~sts_clr) | (chg & ~prev_reg);
         irq     <= |(((sts_reg & ~sts_clr) | (chg & ~prev_reg)) & mask_reg);
      end
   end

   // Read mux; unmapped reads return zero
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         wb_dat_o <= 32'h0;
      else if (rd)
      begin
         case (wb_adr_i)
            `OXS_CTRL_OFF:    wb_dat_o <= {30'h0, ctrl_reg};
            `OXS_FORCE_OFF:   wb_dat_o <= {30'h0, force_reg};
            `OXS_GSEL_OFF:    wb_dat_o <= {25'h0, grp, gsel_sw_reg, gsel_val_reg};
            `OXS_GIDX_OFF:    wb_dat_o <= {29'h0, gidx_reg};
            `OXS_PICKUP_OFF:  wb_dat_o <= {16'h0, pickup_reg[gidx_reg]};
            `OXS_DELAY_OFF:   wb_dat_o <= {12'h0, delay_reg[gidx_reg]};
            `OXS_ALARM_OFF:   wb_dat_o <= {12'h0, alarm_reg[gidx_reg]};
            `OXS_DTYPE_OFF:   wb_dat_o <= {30'h0, dtype_reg[gidx_reg]};
            `OXS_COND_OFF:    wb_dat_o <= {29'h0, cond_reg};
            `OXS_STS_OFF:     wb_dat_o <= {29'h0, sts_reg};
            `OXS_MASK_OFF:    wb_dat_o <= {29'h0, mask_reg};
            `OXS_CNT_ST_OFF:  wb_dat_o <= cnt_reg[0];
            `OXS_CNT_TR_OFF:  wb_dat_o <= cnt_reg[1];
            `OXS_CNT_BL_OFF:  wb_dat_o <= cnt_reg[2];
            `OXS_NOM_OFF:     wb_dat_o <= nom_reg;
            `OXS_EVT_TS_OFF:  wb_dat_o <= ms_reg;
            default:          wb_dat_o <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_edge_seen;
      chg[0] && !prev_reg[0];
   endsequence

   a_start_unblocked: assert property (@(posedge clk) disable iff (!rst_b)
      !ctrl_reg[0] && blk |=> !start_out)
      else $error("start raised while blocked");
   a_edge_event: assert property (@(posedge clk) disable iff (!rst_b)
      s_edge_seen |-> ##[1:3] (evt_valid && evt_code == 3'h0 && evt_on))
      else $error("start edge without event");
   a_force_trip: assert property (@(posedge clk) disable iff (!rst_b)
      ctrl_reg[0] && force_reg == 2'h2 |=> trip_out && start_out && !blocked_out)
      else $error("forced trip not shown");
   a_trip_needs_start: assert property (@(posedge clk) disable iff (!rst_b)
      trip_out |-> start_out)
      else $error("trip without start");
   a_count_start: assert property (@(posedge clk) disable iff (!rst_b)
      (s_edge_seen and !cnt_clr[0]) |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h1)
      else $error("start counter missed");
   a_ms_step: assert property (@(posedge clk) disable iff (!rst_b)
      ms_tick |=> ms_reg == $past(ms_reg) + 32'h1)
      else $error("stamp step wrong");
   a_hyst_hold: assert property (@(posedge clk) disable iff (!rst_b)
      s1_reg && pickup_reg_q && f_reg != '0 && lhs >= thr_rel |=> pickup_reg_q)
      else $error("pick-up released above reset ratio");
   a_pickup_set: assert property (@(posedge clk) disable iff (!rst_b)
      s1_reg && f_reg != '0 && lhs > thr |=> pickup_reg_q)
      else $error("pick-up missed");
   a_cond_blocked: assert property (@(posedge clk) disable iff (!rst_b)
      blocked_out |-> cond_reg == oxs_pkg::OXS_C_BLOCKED)
      else $error("condition not blocked");

endmodule
`default_nettype wire

// *** oxs_front_model.sv ***
// Measurement front end and event buffer model for the overexcitation stage
`timescale 1ns/1ns
`default_nettype none
module oxs_front_model
#(
   parameter int PER = 40
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Values the bench wants presented
   input  wire logic [15:0] v12,
   input  wire logic [15:0] v23,
   input  wire logic [15:0] v31,
   input  wire logic [15:0] f,
   // Measurement side
   output logic             meas_valid,
   output logic [15:0]      line_voltage_rms_12,
   output logic [15:0]      line_voltage_rms_23,
   output logic [15:0]      line_voltage_rms_31,
   output logic [15:0]      freq_meas,
   // Event buffer side
   input  wire logic        evt_valid,
   input  wire logic [2:0]  evt_code,
   input  wire logic        evt_on,
   input  wire logic [31:0] evt_stamp
);
   int          cnt;
   logic [35:0] evq[$];

   // One pulse per shortened time base
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt        <= 0;
         meas_valid <= 1'b0;
      end
      else
      begin
         cnt        <= (cnt == PER - 1) ? 0 : cnt + 1;
         meas_valid <= (cnt == PER - 1);
      end
   end

   // Values are only good in the pulse; inverted otherwise so a late sample shows
   assign line_voltage_rms_12 = meas_valid ? v12 : ~v12;
   assign line_voltage_rms_23 = meas_valid ? v23 : ~v23;
   assign line_voltage_rms_31 = meas_valid ? v31 : ~v31;
   assign freq_meas           = meas_valid ? f : ~f;

   // Event buffer keeps every event in arrival order
   always @(posedge clk)
   begin
      if (evt_valid === 1'b1)
         evq.push_back({evt_code, evt_on, evt_stamp});
   end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the overexcitation stage
`include "oxs_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        clk, rst_b, cyc, stb, we, ack, block_in, meas_valid;
   logic        start_out, trip_out, blocked_out, evt_valid, evt_on, irq;
   logic [2:0]  gsel, evt_code;
   logic [3:0]  sel;
   logic [7:0]  adr;
   logic [15:0] v12, v23, v31, f, m12, m23, m31, mf;
   logic [31:0] wdat, rdat, evt_stamp, q, s1, s2;
   logic [31:0] fexp[4] = '{32'h0, 32'h1, 32'h3, 32'h4};
   int          num_errors, checked;
   time         t_rel;

   oxs_stage i_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .meas_valid(meas_valid), .line_voltage_rms_12(m12), .line_voltage_rms_23(m23),
      .line_voltage_rms_31(m31), .freq_meas(mf), .block_in(block_in), .group_sel_in(gsel),
      .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out), .evt_valid(evt_valid),
      .evt_code(evt_code), .evt_on(evt_on), .evt_stamp(evt_stamp), .irq(irq));

   oxs_front_model i_front (.clk(clk), .rst_b(rst_b), .v12(v12), .v23(v23), .v31(v31), .f(f),
      .meas_valid(meas_valid), .line_voltage_rms_12(m12), .line_voltage_rms_23(m23),
      .line_voltage_rms_31(m31), .freq_meas(mf), .evt_valid(evt_valid), .evt_code(evt_code),
      .evt_on(evt_on), .evt_stamp(evt_stamp));

   // ----------------------------------------------------------------
   // Bus, compare and wait tasks
   // ----------------------------------------------------------------
   task conclude;
      if (num_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   // Classic cycle: hold everything until ack is sampled, then idle one cycle
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (n >= 20)
         num_errors++;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task rc(input string n, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(n, q, e);
   endtask

   task co(input logic [2:0] e);
      chk("outputs", {29'h0, blocked_out, trip_out, start_out}, {29'h0, e});
   endtask

   // Waits out n measurement pulses plus the stage latency
   task tick(input int n);
      repeat (n)
      begin
         @(posedge clk);
         while (meas_valid !== 1'b1)
            @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask

   task ev(input logic [2:0] c, input logic o);
      logic [35:0] e;
      e = 'x;
      if (i_front.evq.size() > 0)
         e = i_front.evq.pop_front();
      chk("evt_code", {29'h0, e[35:33]}, {29'h0, c});
      chk("evt_on", {31'h0, e[32]}, {31'h0, o});
      s2 = s1;
      s1 = e[31:0];
   endtask

   // 10 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Watchdog sized well above the whole sequence
   initial
   begin
      repeat (90000) @(posedge clk);
      num_errors++;
      conclude;
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst_b, cyc, stb, we, block_in, gsel, adr, wdat} = '0;
      {v12, v23, v31, f} = {16'd50, 16'd60, 16'd55, 16'd100};
      sel = 4'hf;
      num_errors = 0;
      checked = 0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_rel = $time;
      rc("pickup", `OXS_PICKUP_OFF, 32'h1f4);
      rc("delay", `OXS_DELAY_OFF, 32'h28);
      rc("nom", `OXS_NOM_OFF, 32'h10000);
      rc("cond", `OXS_COND_OFF, 32'h0);
      rc("unmapped", 8'h44, 32'h0);
      // Partial-lane write is ignored
      sel <= 4'h3;
      wr(`OXS_PICKUP_OFF, 32'h64);
      sel <= 4'hf;
      rc("pickup", `OXS_PICKUP_OFF, 32'h1f4);
      wr(`OXS_MASK_OFF, 32'h7);
      wr(`OXS_DELAY_OFF, 32'h0);
      repeat (25000) @(posedge clk);
      // Instant operation: largest line voltage 110 against 105 threshold
      v23 <= 16'd110;
      tick(2);
      co(3'h3);
      ev(3'h0, 1'b1);
      ev(3'h1, 1'b1);
      chk("stamp_pair", s1, s2);
      wb(1'b0, `OXS_EVT_TS_OFF, 32'h0);
      chk("stamp_ms", q, 32'(($time - t_rel) / 1000000));
      chk("stamp_evt", s1, q);
      chk("irq", {31'h0, irq}, 32'h1);
      rc("status", `OXS_STS_OFF, 32'h3);
      rc("cond", `OXS_COND_OFF, 32'h3);
      // Hysteresis: 103 holds, 101 is under 97 percent of 105
      v23 <= 16'd103;
      tick(2);
      co(3'h3);
      v23 <= 16'd101;
      tick(2);
      co(3'h0);
      ev(3'h0, 1'b0);
      ev(3'h1, 1'b0);
      // Mask, then write-one-to-clear
      wr(`OXS_MASK_OFF, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(`OXS_MASK_OFF, 32'h7);
      wr(`OXS_STS_OFF, 32'h3);
      rc("status", `OXS_STS_OFF, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      // Blocked pick-up gives no start
      block_in <= 1'b1;
      v23 <= 16'd110;
      tick(2);
      co(3'h4);
      rc("cond", `OXS_COND_OFF, 32'h4);
      ev(3'h2, 1'b1);
      v23 <= 16'd50;
      tick(2);
      block_in <= 1'b0;
      tick(1);
      ev(3'h2, 1'b0);
      for (int i = 0; i < 3; i++)
         rc("count", `OXS_CNT_ST_OFF + 8'(4 * i), 32'h1);
      wr(`OXS_CNT_CLR_OFF, 32'h7);
      for (int i = 0; i < 3; i++)
         rc("count", `OXS_CNT_ST_OFF + 8'(4 * i), 32'h0);
      // Fixed delay of 10 ms is two time bases; alarm after one
      wr(`OXS_DELAY_OFF, 32'ha);
      wr(`OXS_ALARM_OFF, 32'h5);
      v23 <= 16'd110;
      tick(1);
      co(3'h1);
      rc("cond", `OXS_COND_OFF, 32'h1);
      tick(1);
      co(3'h1);
      rc("cond", `OXS_COND_OFF, 32'h2);
      tick(2);
      co(3'h3);
      v23 <= 16'd50;
      tick(2);
      // Group 1 with 10 percent pick-up ignores 108; group 0 takes it
      wr(`OXS_GIDX_OFF, 32'h1);
      wr(`OXS_PICKUP_OFF, 32'h3e8);
      gsel <= 3'h1;
      v23 <= 16'd108;
      tick(2);
      co(3'h0);
      rc("gsel", `OXS_GSEL_OFF, 32'h10);
      gsel <= 3'h0;
      tick(2);
      co(3'h1);
      v23 <= 16'd50;
      tick(2);
      // Every forced state, then a group change leaves the setting alone
      wr(`OXS_CTRL_OFF, 32'h1);
      for (int k = 0; k < 4; k++)
      begin
         wr(`OXS_FORCE_OFF, 32'(k));
         repeat (3) @(posedge clk);
         chk("forced", {29'h0, blocked_out, trip_out, start_out}, fexp[k]);
      end
      gsel <= 3'h5;
      rc("force", `OXS_FORCE_OFF, 32'h3);
      wr(`OXS_CTRL_OFF, 32'h0);
      gsel <= 3'h0;
      // Delay type codes, the spare code reads back as fixed
      for (int k = 0; k < 4; k++)
      begin
         wr(`OXS_DTYPE_OFF, 32'(k));
         rc("dtype", `OXS_DTYPE_OFF, (k == 3) ? 32'h0 : 32'(k));
      end
      conclude;
   end
endmodule
`default_nettype wire
